// ===== psc_pkg.sv
// Purpose: Shared constants and types for the PHY shadow control bank
// Assumes: 32-bit classic Wishbone, word addressed by byte address
// Notes: Shadow views share one register address
package psc_pkg;
  localparam logic [7:0] PSC_ADDR_SHADOW = 8'h30;
  localparam logic [7:0] PSC_ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] PSC_ADDR_IRQ_MASK = 8'h44;
  localparam logic [7:0] PSC_ADDR_LIVE = 8'h48;

  localparam logic [2:0] PSC_SEL_AUX = 3'h0;
  localparam logic [2:0] PSC_SEL_TENBT = 3'h1;
  localparam logic [2:0] PSC_SEL_POWER = 3'h2;
  localparam logic [2:0] PSC_SEL_TEST = 3'h4;
  localparam logic [2:0] PSC_SEL_MISC = 3'h7;

  localparam int PSC_SEL_LSB = 0;
  localparam int PSC_RDSEL_LSB = 12;
  localparam int PSC_WREN_BIT = 15;

  // 10BASE-T view bits
  localparam int PSC_B_CODE_ERR = 15;
  localparam int PSC_B_EOF_ERR = 14;
  localparam int PSC_B_POL_INV = 13;
  localparam int PSC_B_IPG_EXT = 12;
  localparam int PSC_B_TXC_INV = 11;
  localparam int PSC_B_JAB_DIS = 9;
  localparam int PSC_B_ECHO = 6;
  localparam int PSC_B_SQE = 5;
  localparam int PSC_B_NIBBLE = 4;
  // Power view
  localparam int PSC_B_SUPER_ISO = 5;
  // Test view
  localparam int PSC_B_LINE_LB = 15;
  localparam int PSC_B_PAIR_SWAP = 4;
  localparam int PSC_B_HALF_AMP = 3;

  // Writable masks of bits 15:3 in each view
  localparam logic [15:0] PSC_WMASK_AUX = 16'hF438;
  localparam logic [15:0] PSC_WMASK_TENBT = 16'h1A70;
  localparam logic [15:0] PSC_WMASK_POWER = 16'h0060;
  localparam logic [15:0] PSC_WMASK_TEST = 16'h8018;
  localparam logic [15:0] PSC_WMASK_MISC = 16'h7A18;
  localparam logic [15:0] PSC_WMASK_RDSEL = 16'h7000;

  localparam logic [15:0] PSC_RST_AUX = 16'h0400;
  localparam logic [15:0] PSC_RST_TENBT = 16'h0000;
  localparam logic [15:0] PSC_RST_POWER = 16'h0060;
  localparam logic [15:0] PSC_RST_TEST = 16'h0000;
  localparam logic [15:0] PSC_RST_MISC = 16'h0010;

  localparam int PSC_IPG_EXTRA = 4;
  localparam int PSC_NVIEW = 5;
  localparam logic [2:0] PSC_IRQ_W = 3'h7;

  typedef struct packed {
    logic code_err;
    logic eof_err;
    logic pol_inv;
  } psc_phy_status_t;

  typedef struct packed {
    logic ipg_extend;
    logic txc_invert;
    logic jabber_disable;
    logic echo;
    logic sqe_enable;
    logic nibble_correction_enable;
    logic super_isolate;
    logic line_loopback;
    logic receive_pair_swap;
    logic half_amplitude_transmit;
  } psc_ctrl_t;
endpackage

// ===== psc_view_mem.sv
// Purpose: Storage for the five writable shadow views
// Assumes: Single write port, registered read
// Notes: Unwritable bits are masked on write
`timescale 1ns/1ps
`default_nettype none
module psc_view_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [2:0] widx_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] wmask_i,
  input wire logic [2:0] ridx_i,
  output logic [15:0] rdata_o,
  output logic [15:0] view_tenbt_o,
  output logic [15:0] view_power_o,
  output logic [15:0] view_test_o
);
  logic [15:0] mem_reg [psc_pkg::PSC_NVIEW];
  integer i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_reg[0] <= psc_pkg::PSC_RST_AUX;
      mem_reg[1] <= psc_pkg::PSC_RST_TENBT;
      mem_reg[2] <= psc_pkg::PSC_RST_POWER;
      mem_reg[3] <= psc_pkg::PSC_RST_TEST;
      mem_reg[4] <= psc_pkg::PSC_RST_MISC;
      rdata_o <= 16'h0000;
    end else begin
      for (i = 0; i < psc_pkg::PSC_NVIEW; i = i + 1) begin
        if (we_i && widx_i == 3'(i)) begin
          mem_reg[i] <= (mem_reg[i] & ~wmask_i) | (wdata_i & wmask_i);
        end
      end
      rdata_o <= (ridx_i < 3'(psc_pkg::PSC_NVIEW)) ? mem_reg[ridx_i] : 16'h0000;
    end
  end

  assign view_tenbt_o = mem_reg[1];
  assign view_power_o = mem_reg[2];
  assign view_test_o = mem_reg[3];
endmodule
`default_nettype wire

// ===== psc_lh_flag.sv
// Purpose: Latched-high status bit cleared by read
// Assumes: Event and read on the same clock
// Notes: A new event beats a clearing read
`timescale 1ns/1ps
`default_nettype none
module psc_lh_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire logic rd_clr_i,
  output logic flag_o
);
  logic flag_next;
  assign flag_next = event_i | (flag_o & ~rd_clr_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_next;
    end
  end
endmodule
`default_nettype wire

// ===== psc_bank.sv
// Purpose: PHY shadow control bank behind a Wishbone slave
// Assumes: PHY status inputs come from pins, synchronised here
// Notes: Ack two cycles after the request for reads and writes
//
// Operation
// - Latch Manchester code error, read-only bit 15
// - Latch end-of-frame error, read-only bit 14
// - Report receive polarity inversion, bit 13
// - Block receive valid four extra clocks at frame start
// - Invert transmit clock when bit set
// - Jabber protection off while bit one
// - Echo transmit data into receive path
// - Correct dribble nibble when bit set
// - Decode shadow select 000/001/010/100/111
// - Super isolate stops link pulse transmission
// - Line-side loopback when bit set
// - Swap receive pair onto transmit pair
// - Half amplitude 10BASE-T transmit
// - Read view chosen by misc read selector
// - Write updates only the addressed view
`timescale 1ns/1ps
`default_nettype none
module psc_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic code_err_i,
  input wire logic eof_err_i,
  input wire logic pol_inv_i,
  input wire logic rx_dv_i,
  input wire logic rx_d_i,
  input wire logic tx_en_i,
  input wire logic tx_d_i,
  input wire logic txc_i,
  input wire logic jabber_i,
  input wire logic dribble_i,
  output logic rx_dv_o,
  output logic rx_d_o,
  output logic txc_o,
  output logic jabber_active_o,
  output logic dribble_trim_o,
  output logic link_pulse_en_o,
  output logic line_loopback_o,
  output logic receive_pair_swap_o,
  output logic half_amplitude_transmit_o,
  output logic sqe_enable_o,
  output logic irq_o
);
  typedef enum logic [1:0] {PSC_IDLE, PSC_READ, PSC_DONE} psc_state_t;
  psc_state_t state_reg;
  psc_state_t state_next;

  // Pin synchronisers, first stage read only by the second
  logic [2:0] st_meta_reg;
  logic [2:0] st_sync_reg;
  psc_pkg::psc_phy_status_t phy_st;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_meta_reg <= 3'h0;
      st_sync_reg <= 3'h0;
    end else begin
      st_meta_reg <= {code_err_i, eof_err_i, pol_inv_i};
      st_sync_reg <= st_meta_reg;
    end
  end
  assign phy_st = st_sync_reg;

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i;
  // Writes land only at the edge where ack is seen, as the master expects
  wire commit = req & wb_ack_o;
  wire wr_lo = wb_sel_i[0];
  wire wr_hi = wb_sel_i[1];
  wire hit_shadow = (wb_adr_i == psc_pkg::PSC_ADDR_SHADOW);
  wire hit_status = (wb_adr_i == psc_pkg::PSC_ADDR_IRQ_STATUS);
  wire hit_mask = (wb_adr_i == psc_pkg::PSC_ADDR_IRQ_MASK);
  wire hit_live = (wb_adr_i == psc_pkg::PSC_ADDR_LIVE);
  wire [15:0] wdata = wb_dat_i[15:0];
  wire [15:0] lane_mask = {{8{wr_hi}}, {8{wr_lo}}};
  wire [2:0] wsel = wdata[psc_pkg::PSC_SEL_LSB +: 3];
  wire wren_set = wdata[psc_pkg::PSC_WREN_BIT];

  function automatic logic [2:0] view_index(input logic [2:0] code);
    case (code)
      psc_pkg::PSC_SEL_AUX: view_index = 3'h0;
      psc_pkg::PSC_SEL_TENBT: view_index = 3'h1;
      psc_pkg::PSC_SEL_POWER: view_index = 3'h2;
      psc_pkg::PSC_SEL_TEST: view_index = 3'h3;
      psc_pkg::PSC_SEL_MISC: view_index = 3'h4;
      default: view_index = 3'h7;
    endcase
  endfunction

  function automatic logic [15:0] view_wmask(input logic [2:0] code, input logic wren);
    case (code)
      psc_pkg::PSC_SEL_AUX: view_wmask = psc_pkg::PSC_WMASK_AUX;
      psc_pkg::PSC_SEL_TENBT: view_wmask = psc_pkg::PSC_WMASK_TENBT;
      psc_pkg::PSC_SEL_POWER: view_wmask = psc_pkg::PSC_WMASK_POWER;
      psc_pkg::PSC_SEL_TEST: view_wmask = psc_pkg::PSC_WMASK_TEST;
      psc_pkg::PSC_SEL_MISC: view_wmask = wren ? psc_pkg::PSC_WMASK_MISC : psc_pkg::PSC_WMASK_RDSEL;
      default: view_wmask = 16'h0000;
    endcase
  endfunction

  // Shadow write: field bits and code in one write
  wire shadow_wr = commit & wb_we_i & hit_shadow;
  wire [2:0] widx = view_index(wsel);
  wire [15:0] wmask = view_wmask(wsel, wren_set) & lane_mask;

  // Read selector lives in the misc view bits 14:12
  logic [15:0] view_tenbt;
  logic [15:0] view_power;
  logic [15:0] view_test;
  logic [15:0] mem_rdata;
  logic [2:0] rdsel_reg;
  wire misc_sel_wr = shadow_wr & (wsel == psc_pkg::PSC_SEL_MISC) & ~wren_set & wr_hi;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdsel_reg <= psc_pkg::PSC_SEL_AUX;
    end else if (misc_sel_wr) begin
      rdsel_reg <= wdata[psc_pkg::PSC_RDSEL_LSB +: 3];
    end
  end
  wire [2:0] ridx = view_index(rdsel_reg);

  psc_view_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(shadow_wr),
    .widx_i(widx),
    .wdata_i(wdata),
    .wmask_i(wmask),
    .ridx_i(ridx),
    .rdata_o(mem_rdata),
    .view_tenbt_o(view_tenbt),
    .view_power_o(view_power),
    .view_test_o(view_test)
  );

  // Latched error bits, cleared by a read of the 10BASE-T view
  // A write to the shadow address must not eat pending error bits
  wire tenbt_rd = (state_reg == PSC_READ) & ~wb_we_i & hit_shadow & (rdsel_reg == psc_pkg::PSC_SEL_TENBT);
  logic code_flag;
  logic eof_flag;
  psc_lh_flag u_code (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(phy_st.code_err),
    .rd_clr_i(tenbt_rd),
    .flag_o(code_flag)
  );
  psc_lh_flag u_eof (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(phy_st.eof_err),
    .rd_clr_i(tenbt_rd),
    .flag_o(eof_flag)
  );

  wire [15:0] tenbt_live = {code_flag, eof_flag, phy_st.pol_inv, 13'h0000};
  wire [15:0] shadow_rd = (ridx == 3'h1) ? (mem_rdata | tenbt_live) : mem_rdata;

  // Interrupt status, write one to clear, set wins
  logic [2:0] irq_st_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] st_prev_reg;
  wire [2:0] st_now = {phy_st.code_err, phy_st.eof_err, phy_st.pol_inv};
  wire [2:0] st_rise = st_now & ~st_prev_reg;
  wire st_clr_wr = commit & wb_we_i & hit_status & wr_lo;
  wire mask_wr = commit & wb_we_i & hit_mask & wr_lo;
  wire [2:0] irq_clr = st_clr_wr ? wdata[2:0] : 3'h0;
  wire [2:0] irq_st_next = st_rise | (irq_st_reg & ~irq_clr);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      st_prev_reg <= 3'h0;
    end else begin
      irq_st_reg <= irq_st_next;
      st_prev_reg <= st_now;
      if (mask_wr) begin
        irq_mask_reg <= wdata[2:0] & psc_pkg::PSC_IRQ_W;
      end
    end
  end
  assign irq_o = |(irq_st_reg & irq_mask_reg);

  // Bus sequencer; one wait cycle lets the view memory register its output
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSC_IDLE: if (req) state_next = PSC_READ;
      PSC_READ: state_next = PSC_DONE;
      PSC_DONE: state_next = PSC_IDLE;
      default: state_next = PSC_IDLE;
    endcase
  end
  wire [31:0] rd_mux = hit_shadow ? {16'h0000, shadow_rd} :
                       hit_status ? {29'h0, irq_st_reg} :
                       hit_mask ? {29'h0, irq_mask_reg} :
                       hit_live ? {29'h0, st_now} : 32'h0000_0000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PSC_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      wb_ack_o <= (state_reg == PSC_READ);
      if (state_reg == PSC_READ) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Datapath controls from the stored views
  psc_pkg::psc_ctrl_t ctrl;
  assign ctrl.ipg_extend = view_tenbt[psc_pkg::PSC_B_IPG_EXT];
  assign ctrl.txc_invert = view_tenbt[psc_pkg::PSC_B_TXC_INV];
  assign ctrl.jabber_disable = view_tenbt[psc_pkg::PSC_B_JAB_DIS];
  assign ctrl.echo = view_tenbt[psc_pkg::PSC_B_ECHO];
  assign ctrl.sqe_enable = view_tenbt[psc_pkg::PSC_B_SQE];
  assign ctrl.nibble_correction_enable = view_tenbt[psc_pkg::PSC_B_NIBBLE];
  assign ctrl.super_isolate = view_power[psc_pkg::PSC_B_SUPER_ISO];
  assign ctrl.line_loopback = view_test[psc_pkg::PSC_B_LINE_LB];
  assign ctrl.receive_pair_swap = view_test[psc_pkg::PSC_B_PAIR_SWAP];
  assign ctrl.half_amplitude_transmit = view_test[psc_pkg::PSC_B_HALF_AMP];

  // Receive valid hold-off counter; clk_i stands in for the receive clock
  logic [2:0] ipg_cnt_reg;
  logic dv_prev_reg;
  wire dv_src = ctrl.echo ? tx_en_i : rx_dv_i;
  wire d_src = ctrl.echo ? tx_d_i : rx_d_i;
  wire dv_rise = dv_src & ~dv_prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ipg_cnt_reg <= 3'h0;
      dv_prev_reg <= 1'b0;
      rx_dv_o <= 1'b0;
      rx_d_o <= 1'b0;
    end else begin
      dv_prev_reg <= dv_src;
      if (dv_rise && ctrl.ipg_extend) begin
        // Rise cycle is itself blocked, so count one less
        ipg_cnt_reg <= 3'(psc_pkg::PSC_IPG_EXTRA - 1);
      end else if (ipg_cnt_reg != 3'h0) begin
        ipg_cnt_reg <= ipg_cnt_reg - 3'h1;
      end
      rx_dv_o <= dv_src & ~(dv_rise & ctrl.ipg_extend) & (ipg_cnt_reg == 3'h0);
      rx_d_o <= d_src;
    end
  end

  // Clock path is combinational; only the inversion is added
  assign txc_o = txc_i ^ ctrl.txc_invert;
  assign jabber_active_o = jabber_i & ~ctrl.jabber_disable;
  assign dribble_trim_o = dribble_i & ctrl.nibble_correction_enable;
  assign link_pulse_en_o = ~ctrl.super_isolate;
  assign line_loopback_o = ctrl.line_loopback;
  assign receive_pair_swap_o = ctrl.receive_pair_swap;
  assign half_amplitude_transmit_o = ctrl.half_amplitude_transmit;
  assign sqe_enable_o = ctrl.sqe_enable;
endmodule
`default_nettype wire

// ===== psc_bank_chk.sv
// Purpose: Port checks for the shadow control bank
// Assumes: One clock, sync reset, two-cycle ack
// Notes: Control bits are seen only through their pin effects
`timescale 1ns/1ps
`default_nettype none
module psc_bank_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_dv_i,
  input wire logic tx_en_i,
  input wire logic txc_i,
  input wire logic jabber_i,
  input wire logic dribble_i,
  input wire logic rx_dv_o,
  input wire logic txc_o,
  input wire logic jabber_active_o,
  input wire logic dribble_trim_o,
  input wire logic link_pulse_en_o,
  input wire logic line_loopback_o,
  input wire logic receive_pair_swap_o,
  input wire logic half_amplitude_transmit_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic wr = req && wb_we_i;
  wire logic known = wb_adr_i inside {psc_pkg::PSC_ADDR_SHADOW, psc_pkg::PSC_ADDR_IRQ_STATUS,
    psc_pkg::PSC_ADDR_IRQ_MASK, psc_pkg::PSC_ADDR_LIVE};
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_delay_a: assert property ($rose(req) |-> ##1 !wb_ack_o ##1 wb_ack_o)
    else $error("ack not two cycles after request");
  unmapped_zero_a: assert property (req && !wb_we_i && wb_ack_o && !known |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  jabber_gate_a: assert property (jabber_active_o |-> jabber_i)
    else $error("jabber active without condition");
  dribble_gate_a: assert property (dribble_trim_o |-> dribble_i)
    else $error("dribble trim without dribble");
  // A control pin moving without a write means a stray register update
  txc_mode_a: assert property ($changed(txc_o ^ txc_i) |-> $past(wr) || $past(wr, 2))
    else $error("clock inversion changed without write");
  isolate_mode_a: assert property ($changed(link_pulse_en_o) |-> $past(wr) || $past(wr, 2))
    else $error("link pulse enable changed without write");
  test_mode_a: assert property ($changed({line_loopback_o, receive_pair_swap_o, half_amplitude_transmit_o})
    |-> $past(wr) || $past(wr, 2))
    else $error("test controls changed without write");
  rx_valid_src_a: assert property (rx_dv_o |-> $past(rx_dv_i || tx_en_i))
    else $error("receive valid without source");
  cover property (wr && wb_ack_o);
  cover property (req && !wb_we_i && wb_ack_o);
  cover property ($rose(irq_o));
endmodule
bind psc_bank psc_bank_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_dv_i(rx_dv_i),
  .tx_en_i(tx_en_i), .txc_i(txc_i), .jabber_i(jabber_i), .dribble_i(dribble_i), .rx_dv_o(rx_dv_o),
  .txc_o(txc_o), .jabber_active_o(jabber_active_o), .dribble_trim_o(dribble_trim_o),
  .link_pulse_en_o(link_pulse_en_o), .line_loopback_o(line_loopback_o),
  .receive_pair_swap_o(receive_pair_swap_o), .half_amplitude_transmit_o(half_amplitude_transmit_o),
  .irq_o(irq_o));
`default_nettype wire

// ===== psc_phy_model.sv
// Purpose: Pin-side PHY model feeding status and data
// Assumes: Same clock as the bank
// Notes: Data toggles at random outside frames too
`timescale 1ns/1ps
`default_nettype none
module psc_phy_model (
  input wire logic clk_i,
  input wire logic [2:0] err_i,
  input wire logic frame_i,
  input wire logic tx_i,
  output psc_pkg::psc_phy_status_t st_o,
  output logic rx_dv_o,
  output logic rx_d_o,
  output logic tx_en_o,
  output logic tx_d_o,
  output logic txc_o,
  output logic jab_o,
  output logic drib_o
);
  initial {st_o, rx_dv_o, rx_d_o, tx_en_o, tx_d_o, txc_o, jab_o, drib_o} = 10'h000;
  // Random data so a stale copy matches by luck only about half the time
  always @(posedge clk_i) begin
    st_o <= err_i;
    {rx_dv_o, tx_en_o} <= {frame_i, tx_i};
    {rx_d_o, tx_d_o, jab_o, drib_o} <= 4'($urandom);
    txc_o <= ~txc_o;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the shadow control bank
// Assumes: Ack at any delay within the watchdog, fixed seed
// Notes: Reads compare writable bits only; live bits hide the rest
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'h3;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_dv_o, rx_d_o, txc_o, jab_o, drib_o, lpe_o, lb_o, sw_o, ha_o, sqe_o, irq_o;
  logic p_dv, p_d, p_txe, p_txd, p_txc, p_jab, p_drib;
  logic [2:0] err = 3'h0;
  logic frame = 1'b0;
  logic tx = 1'b0;
  psc_pkg::psc_phy_status_t st;
  logic [15:0] mdl [8];
  logic [2:0] vs [5];
  int bad_count = 0;
  int n_compared = 0;
  always #2.5 clk_i = ~clk_i;
  psc_phy_model phy_u (.clk_i(clk_i), .err_i(err), .frame_i(frame), .tx_i(tx), .st_o(st), .rx_dv_o(p_dv),
    .rx_d_o(p_d), .tx_en_o(p_txe), .tx_d_o(p_txd), .txc_o(p_txc), .jab_o(p_jab), .drib_o(p_drib));
  psc_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .code_err_i(st.code_err), .eof_err_i(st.eof_err), .pol_inv_i(st.pol_inv), .rx_dv_i(p_dv), .rx_d_i(p_d),
    .tx_en_i(p_txe), .tx_d_i(p_txd), .txc_i(p_txc), .jabber_i(p_jab), .dribble_i(p_drib), .rx_dv_o(rx_dv_o),
    .rx_d_o(rx_d_o), .txc_o(txc_o), .jabber_active_o(jab_o), .dribble_trim_o(drib_o), .link_pulse_en_o(lpe_o),
    .line_loopback_o(lb_o), .receive_pair_swap_o(sw_o), .half_amplitude_transmit_o(ha_o), .sqe_enable_o(sqe_o),
    .irq_o(irq_o));
  function automatic logic [15:0] wm(input logic [2:0] v);
    case (v)
      3'h0: return psc_pkg::PSC_WMASK_AUX;
      3'h1: return psc_pkg::PSC_WMASK_TENBT;
      3'h2: return psc_pkg::PSC_WMASK_POWER;
      3'h4: return psc_pkg::PSC_WMASK_TEST;
      default: return psc_pkg::PSC_WMASK_MISC & 16'h0FFF;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, w, a, d};
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wv(input logic [2:0] v, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'b1, psc_pkg::PSC_ADDR_SHADOW, {16'h0, d[15:3], v}, r);
    mdl[v] = d;
  endtask
  task automatic sel(input logic [2:0] v);
    logic [31:0] r;
    xfer(1'b1, psc_pkg::PSC_ADDR_SHADOW, {17'h0, v, 9'h0, 3'h7}, r);
  endtask
  task automatic rdv(input logic [2:0] v);
    logic [31:0] r;
    sel(v);
    xfer(1'b0, psc_pkg::PSC_ADDR_SHADOW, 32'h0, r);
    chk(r[15:0] & wm(v), mdl[v] & wm(v));
  endtask
  task automatic ports;
    chk({lb_o, sw_o, ha_o}, {mdl[4][15], mdl[4][4], mdl[4][3]});
    chk(lpe_o, !mdl[2][5]);
    chk({txc_o, jab_o, drib_o, sqe_o}, {p_txc ^ mdl[1][11], p_jab & ~mdl[1][9], p_drib & mdl[1][4], mdl[1][5]});
  endtask
  task automatic frm(output int c);
    c = 0;
    for (int k = 0; k < 18; k++) begin
      frame <= (k < 12);
      @(posedge clk_i);
      c += int'(rx_dv_o === 1'b1);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
  initial begin
    logic [31:0] r;
    logic [15:0] d;
    logic [2:0] v;
    int c0;
    int c1;
    logic q;
    void'($urandom(3960));
    mdl = '{psc_pkg::PSC_RST_AUX, psc_pkg::PSC_RST_TENBT, psc_pkg::PSC_RST_POWER, 16'h0,
      psc_pkg::PSC_RST_TEST, 16'h0, 16'h0, psc_pkg::PSC_RST_MISC};
    vs = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ports;
    foreach (vs[i]) rdv(vs[i]);
    // Each write is followed by a read of every view to catch cross-writes
    repeat (4) foreach (vs[i]) begin
      v = vs[$urandom_range(4)];
      d = (16'($urandom) & wm(v)) | ((v == 3'h7) ? 16'h8000 : 16'h0);
      wv(v, d);
      ports;
      foreach (vs[j]) rdv(vs[j]);
    end
    // Low lane only: the upper byte of the test view must survive
    wb_sel <= 4'h1;
    d = mdl[4];
    wv(3'h4, 16'h8018);
    mdl[4] = {d[15:8], 8'h18};
    wb_sel <= 4'h3;
    rdv(3'h4);
    ports;
    xfer(1'b1, 8'h10, 32'h0000FFFF, r);
    xfer(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    err <= 3'b110;
    repeat (4) @(posedge clk_i);
    err <= 3'b100;
    repeat (6) @(posedge clk_i);
    sel(3'h1);
    xfer(1'b0, psc_pkg::PSC_ADDR_SHADOW, 32'h0, r);
    chk(r[15:13], 3'b110);
    xfer(1'b0, psc_pkg::PSC_ADDR_SHADOW, 32'h0, r);
    chk(r[15:13], 3'b100);
    err <= 3'b001;
    repeat (6) @(posedge clk_i);
    xfer(1'b0, psc_pkg::PSC_ADDR_SHADOW, 32'h0, r);
    chk(r[15:13], 3'b101);
    xfer(1'b0, psc_pkg::PSC_ADDR_SHADOW, 32'h0, r);
    chk(r[15:13], 3'b001);
    chk(irq_o, 1'b0);
    xfer(1'b0, psc_pkg::PSC_ADDR_IRQ_STATUS, 32'h0, r);
    chk(r[2:0], 3'h7);
    xfer(1'b1, psc_pkg::PSC_ADDR_IRQ_MASK, 32'h7, r);
    chk(irq_o, 1'b1);
    xfer(1'b1, psc_pkg::PSC_ADDR_IRQ_STATUS, 32'h3, r);
    xfer(1'b0, psc_pkg::PSC_ADDR_IRQ_STATUS, 32'h0, r);
    chk({irq_o, r[2:0]}, 4'hC);
    xfer(1'b1, psc_pkg::PSC_ADDR_IRQ_STATUS, 32'h4, r);
    chk(irq_o, 1'b0);
    err <= 3'b000;
    wv(3'h1, 16'h0000);
    frm(c0);
    wv(3'h1, 16'h1000);
    frm(c1);
    chk(c0, 12);
    chk(c0 - c1, psc_pkg::PSC_IPG_EXTRA);
    wv(3'h1, 16'h0040);
    tx <= 1'b1;
    repeat (3) @(posedge clk_i);
    repeat (8) begin
      q = p_txd;
      @(posedge clk_i);
      chk(rx_d_o, q);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
